// >>> bench/rcst_properties.sv
`timescale 1ns/1ns
`default_nettype none

module rcst_properties
#(
    parameter int PC_WIDTH = 9,
    parameter int DRT_TICKS = 4
)
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic master_clear_pin_n_in,
    input wire logic rc_osc_in,
    input wire rcst_pkg::rcst_core_in_s core_in,
    input wire rcst_pkg::rcst_bus_req_s bus_req_in,
    input wire logic [7:0] bus_rdata_out,
    input wire logic core_reset_out,
    input wire logic [PC_WIDTH-1:0] program_counter_out,
    input wire logic [7:0] core_flags_out,
    input wire logic irq_out
);
    // Raw ticks are counted; sync lag may shift the count by one either way
    logic [2:0] high_cnt;
    logic [7:0] tick_cnt;
    logic quiet;
    assign quiet = high_cnt == 3'h7;
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            high_cnt <= 3'h0;
            tick_cnt <= 8'h00;
        end
        else
        begin
            high_cnt <= !master_clear_pin_n_in ? 3'h0 : (quiet ? high_cnt : high_cnt + 3'h1);
            if (!core_reset_out || !master_clear_pin_n_in || core_in.watchdog_timeout)
                tick_cnt <= 8'h00;
            else if ($rose(rc_osc_in))
                tick_cnt <= tick_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    a_flags_read: assert property (
        $past(bus_req_in.rd) && $past(bus_req_in.addr) == rcst_pkg::ADDR_FLAGS
        |-> bus_rdata_out == $past(core_flags_out)) else $error("flag read wrong");
    a_watchdog_run: assert property (
        !core_reset_out && quiet && !core_in.halt_active && core_in.watchdog_timeout
        |=> core_reset_out && core_flags_out == {5'h01, $past(core_flags_out[2:0])})
        else $error("watchdog reset flags wrong");
    a_watchdog_wake: assert property (
        !core_reset_out && quiet && core_in.halt_active && core_in.watchdog_timeout
        |=> core_reset_out && core_flags_out == {5'h00, $past(core_flags_out[2:0])})
        else $error("watchdog wake flags wrong");
    a_pin_wake: assert property (
        $rose(core_reset_out) && !master_clear_pin_n_in && core_in.halt_active
        && !$past(core_in.watchdog_timeout) |-> core_flags_out[7:3] == 5'h02)
        else $error("pin wake flags wrong");
    a_pin_run: assert property (
        $rose(core_reset_out) && !master_clear_pin_n_in && !core_in.halt_active
        && !$past(core_in.watchdog_timeout)
        |-> core_flags_out == {3'h0, $past(core_flags_out[4:0])}) else $error("pin flags wrong");
    a_pin_holds: assert property (
        !master_clear_pin_n_in [*6] |-> core_reset_out) else $error("core left reset");
    a_pin_taken: assert property (
        !core_reset_out && $fell(master_clear_pin_n_in) |-> ##[1:6] core_reset_out)
        else $error("pin reset not taken");
    a_vector_hold: assert property (
        core_reset_out |-> program_counter_out == '1) else $error("counter not at vector");
    a_counter_step: assert property (
        !core_reset_out && !$past(core_reset_out) && $past(core_in.instr_advance)
        |-> program_counter_out == $past(program_counter_out) + 1'b1) else $error("step wrong");
    a_holdoff_len: assert property (
        $fell(core_reset_out) |-> tick_cnt >= DRT_TICKS - 1 && tick_cnt <= DRT_TICKS + 1)
        else $error("hold-off length wrong");
endmodule : rcst_properties

bind reset_cause_and_startup_timer rcst_properties #(.PC_WIDTH(PC_WIDTH), .DRT_TICKS(DRT_TICKS))
    u_props (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .master_clear_pin_n_in(master_clear_pin_n_in), .rc_osc_in(rc_osc_in), .core_in(core_in),
    .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out), .core_reset_out(core_reset_out),
    .program_counter_out(program_counter_out), .core_flags_out(core_flags_out),
    .irq_out(irq_out));

`default_nettype wire

// >>> bench/rcst_supervisor_model.sv
`timescale 1ns/1ns
`default_nettype none

module rcst_supervisor_model
(
    input wire logic clock_in,
    input wire logic brownout_in,
    output logic pin_n_out,
    output logic rc_osc_out
);
    initial
    begin
        pin_n_out = 1'b1;
        rc_osc_out = 1'b0;
    end
    // Pin is pulled low for as long as the supply dip lasts
    always @(posedge clock_in)
        pin_n_out <= !brownout_in;
    // RC source runs free, unrelated in phase to the core clock
    always #230 rc_osc_out = ~rc_osc_out;
endmodule : rcst_supervisor_model

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic clock_in;
    logic arst_n_in;
    logic brownout;
    logic pin_n;
    logic rc_osc;
    rcst_pkg::rcst_core_in_s core;
    rcst_pkg::rcst_bus_req_s bus_req;
    logic [7:0] rdata;
    logic core_reset;
    logic [8:0] counter;
    logic [7:0] flags;
    logic irq;
    int n_mismatch;
    int checks_done;

    reset_cause_and_startup_timer #(.PC_WIDTH(9), .DRT_TICKS(4)) dut (.clock_in(clock_in),
        .arst_n_in(arst_n_in), .master_clear_pin_n_in(pin_n), .rc_osc_in(rc_osc),
        .core_in(core), .bus_req_in(bus_req), .bus_rdata_out(rdata),
        .core_reset_out(core_reset), .program_counter_out(counter),
        .core_flags_out(flags), .irq_out(irq));
    rcst_supervisor_model partner (.clock_in(clock_in), .brownout_in(brownout),
        .pin_n_out(pin_n), .rc_osc_out(rc_osc));

    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        bus_req.wr <= 1'b1;
        bus_req.addr <= a;
        bus_req.wdata <= d;
        @(posedge clock_in);
        bus_req.wr <= 1'b0;
        #1;
    endtask : bus_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_in);
        bus_req.rd <= 1'b1;
        bus_req.addr <= a;
        @(posedge clock_in);
        bus_req.rd <= 1'b0;
        #1 chk({1'b0, rdata}, {1'b0, e});
    endtask : rd_chk

    task automatic wait_release();
        for (int i = 0; i < 400 && core_reset !== 1'b0; i++)
            @(posedge clock_in) #1;
        chk(core_reset, 1'b0);
    endtask : wait_release

    // Halt level is set together with the event so the latch sees it
    task automatic pulse_watchdog(input logic halt);
        @(posedge clock_in);
        core.halt_active <= halt;
        core.watchdog_timeout <= 1'b1;
        @(posedge clock_in);
        core.watchdog_timeout <= 1'b0;
        #1 chk(core_reset, 1'b1);
    endtask : pulse_watchdog

    task automatic pin_dip(input logic halt, input logic [7:0] e);
        @(posedge clock_in);
        core.halt_active <= halt;
        brownout <= 1'b1;
        repeat (20) @(posedge clock_in);
        brownout <= 1'b0;
        core.halt_active <= 1'b0;
        #1 chk(core_reset, 1'b1);
        chk(flags, e);
        rd_chk(8'h07, 8'h5a);
        wait_release();
    endtask : pin_dip

    task automatic t_power_on();
        chk(flags, rcst_pkg::FLAGS_POR_VALUE);
        chk(counter, 9'h1ff);
        rd_chk(8'h08, 8'h00);
        wait_release();
        rd_chk(8'h10, 8'h08);
    endtask : t_power_on

    task automatic t_registers();
        bus_wr(8'h03, 8'h00);
        rd_chk(8'h03, 8'h18);
        @(posedge clock_in) #1 chk(rdata, 8'h00);
        bus_wr(8'h07, 8'h5a);
        bus_wr(8'h08, 8'ha5);
        bus_wr(8'h20, 8'h33);
        rd_chk(8'h08, 8'ha5);
        rd_chk(8'h20, 8'h00);
        rd_chk(8'h13, 8'h08);
        bus_wr(8'h03, 8'he5);
    endtask : t_registers

    task automatic t_watchdog_run();
        pulse_watchdog(1'b0);
        chk(flags, 8'h0d);
        rd_chk(8'h07, 8'h5a);
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h13, 8'h05);
        wait_release();
        @(posedge clock_in);
        core.instr_advance <= 1'b1;
        @(posedge clock_in) #1 chk(counter, 9'h000);
        repeat (511) @(posedge clock_in);
        core.instr_advance <= 1'b0;
        #1 chk(counter, 9'h1ff);
    endtask : t_watchdog_run

    task automatic t_watchdog_wake();
        bus_wr(8'h03, 8'h02);
        pulse_watchdog(1'b1);
        chk(flags, 8'h02);
        rd_chk(8'h13, 8'h07);
        pulse_watchdog(1'b0);
        chk(flags, 8'h0a);
        wait_release();
    endtask : t_watchdog_wake

    task automatic t_irq();
        bus_wr(8'h11, 8'h0f);
        chk(irq, 1'b0);
        bus_wr(8'h12, 8'h02);
        pulse_watchdog(1'b0);
        chk(irq, 1'b1);
        rd_chk(8'h10, 8'h02);
        bus_wr(8'h12, 8'h00);
        chk(irq, 1'b0);
        wait_release();
        bus_wr(8'h12, 8'h08);
        chk(irq, 1'b1);
        bus_wr(8'h11, 8'h0f);
        chk(irq, 1'b0);
    endtask : t_irq

    task automatic t_second_reset();
        @(posedge clock_in);
        arst_n_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        arst_n_in <= 1'b1;
        #1 chk(flags, 8'h18);
        rd_chk(8'h08, 8'h00);
        wait_release();
    endtask : t_second_reset

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        #800000;
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        arst_n_in = 1'b0;
        brownout = 1'b0;
        core = '0;
        bus_req = '0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (3) @(posedge clock_in);
        arst_n_in <= 1'b1;
        #1 t_power_on();
        t_registers();
        t_watchdog_run();
        t_watchdog_wake();
        bus_wr(8'h03, 8'h21);
        pin_dip(1'b0, 8'h09);
        pin_dip(1'b1, 8'h11);
        t_irq();
        t_second_reset();
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire

// >>> rtl/rcst_drt_timer.sv
`timescale 1ns/1ns
`default_nettype none

module rcst_drt_timer
#(
    parameter int TICKS = 1800
)
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic start_in,
    input wire logic rc_tick_in,
    output logic busy_out,
    output logic done_out
);

    localparam int CNT_W = $clog2(TICKS);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic busy;
        logic done;
    } rcst_timer_s;

    rcst_timer_s r_reg;
    rcst_timer_s r_next;

    generate
        if (TICKS < 2)
        begin : g_check
            $error("rcst_drt_timer needs at least two oscillator ticks");
        end
    endgenerate

    // Counts RC oscillator ticks only, so the hold-off is independent of the core clock
    always_comb
    begin
        r_next = r_reg;
        r_next.done = 1'b0;
        if (start_in)
        begin
            r_next.cnt = '0;
            r_next.busy = 1'b1;
        end
        else if (r_reg.busy && rc_tick_in)
        begin
            if (r_reg.cnt == CNT_W'(TICKS - 1))
            begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end
            else
                r_next.cnt = r_reg.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign busy_out = r_reg.busy;
    assign done_out = r_reg.done;

endmodule : rcst_drt_timer

`default_nettype wire

// >>> rtl/rcst_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module rcst_pin_sync
#(
    parameter int WIDTH = 2
)
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] level_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } rcst_sync_s;

    rcst_sync_s r_reg;
    rcst_sync_s r_next;

    generate
        if (WIDTH < 1)
        begin : g_check
            $error("rcst_pin_sync needs at least one pin");
        end
    endgenerate

    // Level moves only once stages two and three agree, filtering one-cycle glitches
    always_comb
    begin
        r_next = r_reg;
        r_next.s1 = pins_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.lvl = (~(r_reg.s2 ^ r_reg.s3) & r_reg.s3) | ((r_reg.s2 ^ r_reg.s3) & r_reg.lvl);
    end

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign level_out = r_reg.lvl;

endmodule : rcst_pin_sync

`default_nettype wire

// >>> rtl/rcst_pkg.sv
package rcst_pkg;

    // Register map on the plain register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_FLAGS = 8'h03;
    localparam logic [7:0] ADDR_RETAINED = 8'h07;
    localparam logic [7:0] ADDR_SCRATCH = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h11;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h12;
    localparam logic [7:0] ADDR_SEQ_STATE = 8'h13;

    // Core flag register layout
    localparam int FLAG_TIMEOUT_BIT = 4;
    localparam int FLAG_POWERDOWN_BIT = 3;
    localparam logic [7:0] FLAGS_POR_VALUE = 8'h18;
    localparam logic [7:0] FLAGS_WRITE_MASK = 8'he7;
    localparam logic [7:0] FLAGS_PAGE_MASK = 8'he0;

    // Timeout and powerdown pairs per reset cause
    localparam logic [1:0] CAUSE_POR = 2'h3;
    localparam logic [1:0] CAUSE_MASTER_CLEAR_PIN_WAKE = 2'h2;
    localparam logic [1:0] CAUSE_WDT_RUN = 2'h1;
    localparam logic [1:0] CAUSE_WDT_WAKE = 2'h0;

    // Interrupt status bit positions
    localparam int IRQ_W = 4;
    localparam int IRQ_MASTER_CLEAR_PIN = 0;
    localparam int IRQ_WDT = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_RELEASE = 3;

    // Timing
    localparam int CLOCK_HZ = 25000000;
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int DRT_TIME_US = 18000;
    localparam int RC_OSC_HZ = 100000;
    localparam int DRT_TICKS = DRT_TIME_US * (RC_OSC_HZ / 1000) / 1000;
    localparam int PC_WIDTH_DEFAULT = 9;
    localparam int PIN_COUNT = 2;
    localparam int PIN_MASTER_CLEAR_PIN = 0;
    localparam int PIN_RC_OSC = 1;

    typedef enum logic [1:0] {
        RCST_HOLD_PIN,
        RCST_COUNT,
        RCST_RUN
    } rcst_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rcst_bus_req_s;

    typedef struct packed {
        logic watchdog_timeout;
        logic halt_active;
        logic instr_advance;
    } rcst_core_in_s;

endpackage : rcst_pkg

// >>> rtl/reset_cause_and_startup_timer.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none

// Function
// RULE1 - Five causes: power-on, pin reset running or halted, watchdog running or halted.
// RULE2 - Retained registers are unknown at power-on and kept across other resets.
// RULE3 - Other registers take their reset state on power-on, pin and watchdog reset. Interrupt enable and status keep their values across pin and watchdog reset.
// RULE4 - Wake from halt by pin or watchdog is a full reset, no resume.
// RULE5 - Timeout and powerdown flags sit at bits 4 and 3, telling the cause.
// RULE6 - Flags: power-on 1,1; pin running kept; pin wake 1,0; watchdog 0,1 / 0,0.
// RULE7 - Flag register at 03h; power-on clears page bits, sets both cause flags.
// RULE8 - Pin or watchdog reset clears page bits, keeps zero, digit carry and carry.
// RULE9 - Reset hold-off of nominal 18 ms, counted on the internal RC oscillator.
// RULE10 - The core stays in reset while the hold-off timer counts.
// RULE11 - Hold-off starts once the master clear pin is high, then holds until done.
// RULE12 - A watchdog timeout restarts the hold-off timer as well.
// RULE13 - The system should pull master clear low during supply brown-out.
// RULE14 - Program counter is 9, 10 or 11 bits and wraps above the top.
// RULE15 - After reset the program counter starts at the last program word.
// RULE16 - A no-operation at the vector lets the counter wrap to address 000h.
// RULE17 - Latch halt status at pin or watchdog event to pick the flag encoding.
// RULE18 - Release reset synchronously when the timer expires, fetching from the vector.
module reset_cause_and_startup_timer
#(
    parameter int PC_WIDTH = rcst_pkg::PC_WIDTH_DEFAULT,
    parameter int DRT_TICKS = rcst_pkg::DRT_TICKS
)
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic master_clear_pin_n_in,
    input wire logic rc_osc_in,
    input wire rcst_pkg::rcst_core_in_s core_in,
    input wire rcst_pkg::rcst_bus_req_s bus_req_in,
    output logic [7:0] bus_rdata_out,
    output logic core_reset_out,
    output logic [PC_WIDTH-1:0] program_counter_out,
    output logic [7:0] core_flags_out,
    output logic irq_out
);

    typedef struct packed {
        rcst_pkg::rcst_state_e st;
        logic [7:0] flags;
        logic [7:0] retained;
        logic [7:0] scratch;
        logic [rcst_pkg::IRQ_W-1:0] irq_status;
        logic [rcst_pkg::IRQ_W-1:0] irq_enable;
        logic irq;
        logic halt_latch;
        logic rc_prev;
        logic [PC_WIDTH-1:0] pc;
        logic [7:0] rdata;
    } rcst_state_s;

    rcst_state_s r_reg;
    rcst_state_s r_next;

    logic [rcst_pkg::PIN_COUNT-1:0] pin_level;
    logic pin_high;
    logic rc_tick;
    logic timer_start;
    logic timer_busy;
    logic timer_done;
    logic internal_reset;
    logic [rcst_pkg::IRQ_W-1:0] irq_set;
    logic [rcst_pkg::IRQ_W-1:0] irq_clear;

    generate
        if (PC_WIDTH < 9 || PC_WIDTH > 11)
        begin : g_pc_check
            $error("program counter width must be 9, 10 or 11");
        end
    endgenerate

    rcst_pin_sync
    #(
        .WIDTH(rcst_pkg::PIN_COUNT)
    )
    u_pin_sync
    (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .pins_in({rc_osc_in, master_clear_pin_n_in}),
        .level_out(pin_level)
    );

    rcst_drt_timer
    #(
        .TICKS(DRT_TICKS)
    )
    u_drt_timer
    (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .start_in(timer_start),
        .rc_tick_in(rc_tick),
        .busy_out(timer_busy),
        .done_out(timer_done)
    );

    assign pin_high = pin_level[rcst_pkg::PIN_MASTER_CLEAR_PIN];
    assign rc_tick = pin_level[rcst_pkg::PIN_RC_OSC] & ~r_reg.rc_prev; // [RULE9]

    always_comb
    begin
        r_next = r_reg;
        timer_start = 1'b0;
        internal_reset = 1'b0;
        irq_set = '0;
        irq_clear = '0;
        r_next.rdata = 8'h00;
        r_next.rc_prev = pin_level[rcst_pkg::PIN_RC_OSC];

        // Sequencer; events in a cycle are ordered pin first, then watchdog
        case (r_reg.st)
            rcst_pkg::RCST_HOLD_PIN:
            begin
                // Counting waits for the pin to read high after filtering
                if (pin_high)
                begin
                    timer_start = 1'b1; // [RULE11]
                    r_next.st = rcst_pkg::RCST_COUNT;
                end
            end
            rcst_pkg::RCST_COUNT:
            begin
                if (!pin_high)
                begin
                    // Pin dropped again during hold-off: count restarts from zero later
                    r_next.st = rcst_pkg::RCST_HOLD_PIN; // [RULE11]
                end
                else if (core_in.watchdog_timeout)
                begin
                    internal_reset = 1'b1; // [RULE1]
                    irq_set[rcst_pkg::IRQ_WDT] = 1'b1;
                    r_next.halt_latch = 1'b0;
                    r_next.flags[rcst_pkg::FLAG_TIMEOUT_BIT -: 2] = rcst_pkg::CAUSE_WDT_RUN; // [RULE6]
                    timer_start = 1'b1; // [RULE12]
                end
                else if (timer_done)
                begin
                    // Release lands on a core clock edge only
                    r_next.st = rcst_pkg::RCST_RUN; // [RULE18]
                    irq_set[rcst_pkg::IRQ_RELEASE] = 1'b1;
                end
            end
            rcst_pkg::RCST_RUN:
            begin
                if (!pin_high)
                begin
                    internal_reset = 1'b1; // [RULE1]
                    irq_set[rcst_pkg::IRQ_MASTER_CLEAR_PIN] = 1'b1;
                    r_next.halt_latch = core_in.halt_active; // [RULE17]
                    if (core_in.halt_active)
                    begin
                        irq_set[rcst_pkg::IRQ_WAKE] = 1'b1;
                        r_next.flags[rcst_pkg::FLAG_TIMEOUT_BIT -: 2] = rcst_pkg::CAUSE_MASTER_CLEAR_PIN_WAKE; // [RULE6]
                    end
                    // Pin reset while running leaves both cause flags as they were
                    r_next.st = rcst_pkg::RCST_HOLD_PIN; // [RULE4]
                end
                else if (core_in.watchdog_timeout)
                begin
                    internal_reset = 1'b1; // [RULE1]
                    irq_set[rcst_pkg::IRQ_WDT] = 1'b1;
                    r_next.halt_latch = core_in.halt_active; // [RULE17]
                    if (core_in.halt_active)
                    begin
                        irq_set[rcst_pkg::IRQ_WAKE] = 1'b1;
                        r_next.flags[rcst_pkg::FLAG_TIMEOUT_BIT -: 2] = rcst_pkg::CAUSE_WDT_WAKE; // [RULE6]
                    end
                    else
                    begin
                        r_next.flags[rcst_pkg::FLAG_TIMEOUT_BIT -: 2] = rcst_pkg::CAUSE_WDT_RUN; // [RULE6]
                    end
                    timer_start = 1'b1; // [RULE12]
                    r_next.st = rcst_pkg::RCST_COUNT; // [RULE4]
                end
            end
            default:
            begin
                r_next.st = rcst_pkg::RCST_HOLD_PIN;
            end
        endcase

        // Register writes; cause flags are never software writable
        if (bus_req_in.wr)
        begin
            if (bus_req_in.addr == rcst_pkg::ADDR_FLAGS)
            begin
                r_next.flags = (r_next.flags & ~rcst_pkg::FLAGS_WRITE_MASK)
                    | (bus_req_in.wdata & rcst_pkg::FLAGS_WRITE_MASK); // [RULE5]
            end
            else if (bus_req_in.addr == rcst_pkg::ADDR_RETAINED)
            begin
                r_next.retained = bus_req_in.wdata;
            end
            else if (bus_req_in.addr == rcst_pkg::ADDR_SCRATCH)
            begin
                r_next.scratch = bus_req_in.wdata;
            end
            else if (bus_req_in.addr == rcst_pkg::ADDR_IRQ_CLEAR)
            begin
                irq_clear = bus_req_in.wdata[rcst_pkg::IRQ_W-1:0];
            end
            else if (bus_req_in.addr == rcst_pkg::ADDR_IRQ_ENABLE)
            begin
                r_next.irq_enable = bus_req_in.wdata[rcst_pkg::IRQ_W-1:0];
            end
        end

        // A reset in the same cycle overrides writes to scratch, retained word and page bits; retained word is untouched
        if (internal_reset)
        begin
            r_next.flags = r_next.flags & ~rcst_pkg::FLAGS_PAGE_MASK; // [RULE8]
            r_next.scratch = 8'h00; // [RULE3]
            r_next.retained = r_reg.retained; // [RULE2]
        end

        // Set beats clear so an event landing on a clear is not lost
        r_next.irq_status = (r_reg.irq_status & ~irq_clear) | irq_set;
        r_next.irq = |(r_next.irq_status & r_next.irq_enable);

        // Counter sits on the top word whenever the core is held
        if (r_next.st != rcst_pkg::RCST_RUN)
        begin
            r_next.pc = '1; // [RULE15]
        end
        else if (r_reg.st == rcst_pkg::RCST_RUN && core_in.instr_advance)
        begin
            // Natural overflow wraps above the implemented space, so 7ff etc. step to zero
            r_next.pc = r_reg.pc + PC_WIDTH'(1); // [RULE14] [RULE16]
        end

        // Read data stands in the cycle after the strobe only
        if (bus_req_in.rd)
        begin
            if (bus_req_in.addr == rcst_pkg::ADDR_FLAGS)
            begin
                r_next.rdata = r_reg.flags; // [RULE7]
            end
            else if (bus_req_in.addr == rcst_pkg::ADDR_RETAINED)
            begin
                r_next.rdata = r_reg.retained;
            end
            else if (bus_req_in.addr == rcst_pkg::ADDR_SCRATCH)
            begin
                r_next.rdata = r_reg.scratch;
            end
            else if (bus_req_in.addr == rcst_pkg::ADDR_IRQ_STATUS)
            begin
                r_next.rdata = {4'h0, r_reg.irq_status};
            end
            else if (bus_req_in.addr == rcst_pkg::ADDR_IRQ_ENABLE)
            begin
                r_next.rdata = {4'h0, r_reg.irq_enable};
            end
            else if (bus_req_in.addr == rcst_pkg::ADDR_SEQ_STATE)
            begin
                r_next.rdata = {4'h0, r_reg.st, r_reg.halt_latch, timer_busy};
            end
            else
            begin
                r_next.rdata = 8'h00;
            end
        end
    end

    // Power-on: flags 0001_1000 with zero/digit carry/carry taken as 0
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            r_reg <= '0;
            r_reg.st <= rcst_pkg::RCST_HOLD_PIN;
            r_reg.flags <= rcst_pkg::FLAGS_POR_VALUE; // [RULE7] [RULE6]
            r_reg.pc <= '1; // [RULE15]
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Core held from any state but running, including the whole count
    assign core_reset_out = (r_reg.st != rcst_pkg::RCST_RUN); // [RULE10]
    assign program_counter_out = r_reg.pc;
    assign core_flags_out = r_reg.flags;
    assign bus_rdata_out = r_reg.rdata;
    assign irq_out = r_reg.irq;

endmodule : reset_cause_and_startup_timer

`default_nettype wire
